// ---- core_sfr_bank.v ----
/*
 * Core system-controller register bank: stack pointer, data pointer,
 * status word, primary and second operand registers, power control.
 * Software reaches the registers by direct address, bytewise or, for
 * addresses ending in 0x0 or 0x8, bitwise. The surrounding core supplies
 * the execution strobes (stack store, arithmetic results, interrupt
 * return) and consumes the halt and oscillator controls.
 */
// Functional notes
// - Stack pointer increments before each stack store
// - Stack pointer resets to 0x07
// - Low and high bytes form 16-bit data pointer
// - Carry set on carry or borrow, else cleared
// - Half carry tracks nibble carry or borrow
// - Two user flags are plain storage bits
// - Bank select bits pick register bank base
// - Signed range set on overflow, big product, zero divisor
// - Signed range cleared by those ops otherwise
// - Parity bit is odd parity of primary operand
// - Idle select write halts CPU after instruction
// - Registers hold their contents during idle
// - Enabled interrupt ends idle, clears select bit
// - Return resumes after instruction that set idle
// - Reset ends idle or stop, fetch from 0x0000
// - Watchdog reset ends idle when enabled
// - Stop select write stops oscillator and CPU
// - Interrupts do not wake from stop
// - Lost clock detector reset ends stop
// - Power select bits act on one, read zero
// - Bit access only at addresses ending 0x0/0x8
`timescale 1ns/1ns
`include "core_sfr_map.vh"

module core_sfr_bank (
    input  wire        CLK_SYS,         // System clock
    input  wire        RST_N,           // Synchronous reset, active low
    input  wire [7:0]  SFR_ADDR,        // Direct address of the access
    input  wire        SFR_WR,          // Byte write strobe
    input  wire        SFR_RD,          // Byte read strobe
    input  wire [7:0]  SFR_WDATA,       // Byte write data
    input  wire        BIT_WR,          // Bit write strobe
    input  wire        BIT_RD,          // Bit read strobe
    input  wire [2:0]  BIT_POS,         // Bit position within byte
    input  wire        BIT_WDATA,       // Bit write value
    input  wire        STACK_STORE,     // Stack store operation
    input  wire        STACK_LOAD,      // Stack load operation
    input  wire [2:0]  ARITH_OP,        // Arithmetic op executed this cycle
    input  wire [7:0]  ARITH_RESULT,    // Result to place in primary operand
    input  wire        ARITH_WR_B,      // Op also writes the second operand
    input  wire [7:0]  ARITH_RESULT_B,  // Result for the second operand
    input  wire        IRQ_PENDING,     // Enabled interrupt asserted
    input  wire        IRQ_RETURN,      // Interrupt return executed
    output reg  [7:0]  SFR_RDATA,       // Byte read data
    output reg         RD_VALID,        // Read data valid pulse
    output reg         BIT_RDATA,       // Bit read data
    output reg  [7:0]  STACK_ADDR,      // Address for the stack store
    output reg  [15:0] DATA_POINTER_16_ADDR,       // 16-bit data pointer
    output reg  [4:0]  BANK_BASE,       // Base of the active register bank
    output reg         CPU_HALT,        // CPU clock gated
    output reg         OSC_STOP,        // Internal oscillator stopped
    output reg         IDLE_WAKE,       // Idle ended by interrupt, pulse
    output reg         RESUME_NEXT,     // Return from waking interrupt, pulse
    output reg  [15:0] FETCH_ADDR       // Fetch address after reset
);

    // ======================================================================
    // Storage
    // ======================================================================
    reg [7:0] sp_r;             // Stack top pointer
    reg [7:0] dpl_r;            // Data pointer low byte
    reg [7:0] dph_r;            // Data pointer high byte
    reg [7:0] sw_r;             // Status word; parity bit unused here
    reg [7:0] acc_r;            // Primary operand register
    reg [7:0] b_r;              // Second operand register
    reg       woke_r;           // Inside the interrupt that ended idle
    reg [7:0] rd_byte;          // Combinational read mux
    reg [7:0] wr_byte;          // Merged byte after a bit write
    reg       wr_any;           // Byte or bit write to this address
    reg [7:0] sw_nxt;           // Next status word

    wire       arith_op;
    wire       carry_new;
    wire       half_new;
    wire       range_new;
    wire       carry_valid;
    wire       cpu_halt_w;
    wire       osc_stop_w;
    wire       wake_w;
    wire       parity = ^acc_r;
    wire       pc_wr = SFR_WR && (SFR_ADDR == `ADDR_POWER_CTRL);

    // Bit access is only legal where the low nibble is 0x0 or 0x8
    function bit_capable;
        input [7:0] addr;
        begin
            bit_capable = (addr[2:0] == 3'h0);
        end
    endfunction

    // ======================================================================
    // Submodules
    // ======================================================================
    flag_calc u_flags (
        .op_code     (ARITH_OP),
        .op_a        (acc_r),
        .op_b        (b_r),
        .carry_in    (sw_r[`SW_CARRY]),
        .arith_op    (arith_op),
        .carry_out   (carry_new),
        .half_out    (half_new),
        .range_out   (range_new),
        .carry_valid (carry_valid)
    );

    // Reserved power control bits are ignored; software keeps them zero
    power_fsm u_power (
        .CLK_SYS     (CLK_SYS),
        .RST_N       (RST_N),
        .idle_req    (pc_wr && SFR_WDATA[`PC_IDLE_SEL]),
        .stop_req    (pc_wr && SFR_WDATA[`PC_STOP_SEL]),
        .irq_pending (IRQ_PENDING),
        .cpu_halt_r  (cpu_halt_w),
        .osc_stop_r  (osc_stop_w),
        .wake_r      (wake_w)
    );

    // ======================================================================
    // Write path: byte write or read-modify-write of one bit
    // ======================================================================
    always @* begin
        // Read mux kept inline so that @* sees every register it reads;
        // power select bits always read zero
        case (SFR_ADDR)
            `ADDR_STACK_TOP:    rd_byte = sp_r;
            `ADDR_DATA_POINTER_16_LOW:     rd_byte = dpl_r;
            `ADDR_DATA_POINTER_16_HIGH:    rd_byte = dph_r;
            `ADDR_POWER_CTRL:   rd_byte = 8'h00;
            `ADDR_STATUS_FLAGS: rd_byte = {sw_r[7:1], parity};
            `ADDR_PRIMARY_OP:   rd_byte = acc_r;
            `ADDR_SECOND_OP:    rd_byte = b_r;
            default:            rd_byte = 8'h00;
        endcase
        wr_byte = SFR_WDATA;
        wr_any  = SFR_WR;
        if (BIT_WR && bit_capable(SFR_ADDR)) begin
            wr_byte          = rd_byte;
            wr_byte[BIT_POS] = BIT_WDATA;
            wr_any           = 1'b1;
        end
    end

    // ======================================================================
    // Status word next value: software write, then arithmetic flags
    // ======================================================================
    always @* begin
        sw_nxt = sw_r;
        if (wr_any && SFR_ADDR == `ADDR_STATUS_FLAGS) begin
            // User flags and bank select are plain storage
            sw_nxt = {wr_byte[7:1], 1'b0};
        end
        // Hardware results take priority over a software write
        if (arith_op && !cpu_halt_w) begin
            sw_nxt[`SW_SIGNED_RANGE] = range_new;
            if (carry_valid) begin
                sw_nxt[`SW_CARRY]      = carry_new;
                sw_nxt[`SW_HALF_CARRY] = half_new;
            end
        end
    end

    // ======================================================================
    // Registers; nothing changes while the CPU is halted
    // ======================================================================
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sp_r   <= `RST_STACK_TOP;
            dpl_r  <= `RST_BYTE;
            dph_r  <= `RST_BYTE;
            sw_r   <= `RST_BYTE;
            acc_r  <= `RST_BYTE;
            b_r    <= `RST_BYTE;
            woke_r <= 1'b0;
        end else if (!cpu_halt_w) begin
            sw_r <= sw_nxt;
            // Pointer moves first so the store lands on the new top
            if (STACK_STORE) begin
                sp_r <= sp_r + 8'h01;
            end else if (STACK_LOAD) begin
                sp_r <= sp_r - 8'h01;
            end else if (wr_any && SFR_ADDR == `ADDR_STACK_TOP) begin
                sp_r <= wr_byte;
            end
            if (wr_any && SFR_ADDR == `ADDR_DATA_POINTER_16_LOW) begin
                dpl_r <= wr_byte;
            end
            if (wr_any && SFR_ADDR == `ADDR_DATA_POINTER_16_HIGH) begin
                dph_r <= wr_byte;
            end
            if (arith_op) begin
                acc_r <= ARITH_RESULT;
            end else if (wr_any && SFR_ADDR == `ADDR_PRIMARY_OP) begin
                acc_r <= wr_byte;
            end
            if (arith_op && ARITH_WR_B) begin
                b_r <= ARITH_RESULT_B;
            end else if (wr_any && SFR_ADDR == `ADDR_SECOND_OP) begin
                b_r <= wr_byte;
            end
            // Remember that the running handler is the one that ended idle
            if (wake_w) begin
                woke_r <= 1'b1;
            end else if (IRQ_RETURN) begin
                woke_r <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Registered outputs
    // ======================================================================
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            SFR_RDATA   <= 8'h00;
            RD_VALID    <= 1'b0;
            BIT_RDATA   <= 1'b0;
            STACK_ADDR  <= `RST_STACK_TOP;
            DATA_POINTER_16_ADDR   <= 16'h0000;
            BANK_BASE   <= 5'h00;
            CPU_HALT    <= 1'b0;
            OSC_STOP    <= 1'b0;
            IDLE_WAKE   <= 1'b0;
            RESUME_NEXT <= 1'b0;
            FETCH_ADDR  <= `RST_FETCH_ADDR;
        end else begin
            SFR_RDATA  <= SFR_RD ? rd_byte : 8'h00;
            RD_VALID   <= SFR_RD || (BIT_RD && bit_capable(SFR_ADDR));
            BIT_RDATA  <= BIT_RD && bit_capable(SFR_ADDR) && rd_byte[BIT_POS];
            STACK_ADDR <= sp_r;
            DATA_POINTER_16_ADDR  <= {dph_r, dpl_r};
            BANK_BASE  <= {sw_r[`SW_BANK_HI], sw_r[`SW_BANK_LO], 3'h0};
            CPU_HALT   <= cpu_halt_w;
            OSC_STOP   <= osc_stop_w;
            IDLE_WAKE  <= wake_w;
            // Core continues at the instruction after the idle write
            RESUME_NEXT <= woke_r && IRQ_RETURN;
            FETCH_ADDR <= `RST_FETCH_ADDR;
        end
    end

endmodule // core_sfr_bank

// ---- core_sfr_bank_chk.sv ----
/* Checker for the core register bank: read strobes, halt entry, wake, stop hold.
   Assumes it is bound onto core_sfr_bank and sees only that module's ports. */
`timescale 1ns/1ns
module core_sfr_bank_chk (
    input wire       CLK_SYS, RST_N, SFR_WR, SFR_RD, BIT_RD, IRQ_PENDING, RD_VALID,
    input wire [7:0] SFR_ADDR, SFR_WDATA, STACK_ADDR,
    input wire [15:0] DATA_POINTER_16_ADDR, FETCH_ADDR,
    input wire [4:0] BANK_BASE,
    input wire       CPU_HALT, OSC_STOP, IDLE_WAKE
);
    // ==========================================================================
    // Common timing
    // ==========================================================================
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    wire pwr_wr = SFR_WR && SFR_ADDR == 8'h87;  // Power control write

    // ==========================================================================
    // Assertions
    // ==========================================================================
    rd_valid_src_a: assert property (RD_VALID |-> $past(SFR_RD || BIT_RD))
        else $error("read valid without a read strobe");
    // Idle with no interrupt in sight must gate the CPU two edges on
    idle_entry_a: assert property (pwr_wr && SFR_WDATA[0] && !CPU_HALT && !$past(pwr_wr)
        && !IRQ_PENDING ##1 !IRQ_PENDING |-> ##1 CPU_HALT) else $error("idle not entered");
    stop_entry_a: assert property (pwr_wr && SFR_WDATA[1] && !CPU_HALT && !$past(pwr_wr)
        |-> ##2 (OSC_STOP && CPU_HALT)) else $error("stop not entered");
    stop_hold_a: assert property (OSC_STOP |=> OSC_STOP && CPU_HALT)
        else $error("stop left without reset");
    wake_cause_a: assert property (IDLE_WAKE |-> $past(IRQ_PENDING, 2) && !CPU_HALT)
        else $error("wake without interrupt");
    halt_freeze_a: assert property (CPU_HALT [*3] |-> $stable(DATA_POINTER_16_ADDR) && $stable(STACK_ADDR))
        else $error("register changed while halted");
    fetch_zero_a: assert property (FETCH_ADDR == 16'h0000)
        else $error("fetch address not zero");
    bank_align_a: assert property (BANK_BASE[2:0] == 3'h0)
        else $error("bank base not a multiple of eight");
    data_pointer_16_cause_a: assert property ($changed(DATA_POINTER_16_ADDR) |-> $past(SFR_WR) || $past(SFR_WR, 2))
        else $error("data pointer changed without a write");
    cover property (pwr_wr && SFR_WDATA == 8'h03);
    cover property (IDLE_WAKE);
    cover property ($rose(OSC_STOP));
endmodule // core_sfr_bank_chk

bind core_sfr_bank core_sfr_bank_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SFR_WR(SFR_WR),
    .SFR_RD(SFR_RD), .BIT_RD(BIT_RD), .IRQ_PENDING(IRQ_PENDING), .RD_VALID(RD_VALID),
    .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .STACK_ADDR(STACK_ADDR), .DATA_POINTER_16_ADDR(DATA_POINTER_16_ADDR),
    .FETCH_ADDR(FETCH_ADDR), .BANK_BASE(BANK_BASE), .CPU_HALT(CPU_HALT), .OSC_STOP(OSC_STOP),
    .IDLE_WAKE(IDLE_WAKE));

// ---- core_sfr_map.vh ----
/*
 * Core system-controller register map: direct addresses, status word
 * field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the register bank modules.
 */
`ifndef CORE_SFR_MAP_VH
`define CORE_SFR_MAP_VH

// ==========================================================================
// Direct addresses
// ==========================================================================
`define ADDR_STACK_TOP      8'h81
`define ADDR_DATA_POINTER_16_LOW       8'h82
`define ADDR_DATA_POINTER_16_HIGH      8'h83
`define ADDR_POWER_CTRL     8'h87
`define ADDR_STATUS_FLAGS   8'hd0
`define ADDR_PRIMARY_OP     8'he0
`define ADDR_SECOND_OP      8'hf0

// ==========================================================================
// Status word fields
// ==========================================================================
`define SW_CARRY            7
`define SW_HALF_CARRY       6
`define SW_USER_ZERO        5
`define SW_BANK_HI          4
`define SW_BANK_LO          3
`define SW_SIGNED_RANGE     2
`define SW_USER_ONE         1
`define SW_PARITY           0

// ==========================================================================
// Power control fields
// ==========================================================================
`define PC_STOP_SEL         1
`define PC_IDLE_SEL         0

// ==========================================================================
// Reset values
// ==========================================================================
`define RST_STACK_TOP       8'h07
`define RST_BYTE            8'h00
`define RST_FETCH_ADDR      16'h0000

// ==========================================================================
// Arithmetic operation codes on the flag update port
// ==========================================================================
`define OP_NONE             3'h0
`define OP_SUM              3'h1
`define OP_SUM_CARRY        3'h2
`define OP_DIFF_BORROW      3'h3
`define OP_PRODUCT          3'h4
`define OP_QUOTIENT         3'h5

// ==========================================================================
// Timing
// ==========================================================================
`define CLK_PERIOD_NS       10
`define LOST_CLK_TIMEOUT_US 100
`define LOST_CLK_CYCLES     ((`LOST_CLK_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)

`endif

// ---- flag_calc.v ----
/*
 * Flag calculator: carry, half carry and signed range results of the
 * arithmetic operations, computed combinationally from the operands.
 * Assumes operands and operation code are held stable for one cycle.
 */
`timescale 1ns/1ns
`include "core_sfr_map.vh"

module flag_calc (
    input  wire [2:0] op_code,      // Operation being executed
    input  wire [7:0] op_a,         // Primary operand
    input  wire [7:0] op_b,         // Second operand
    input  wire       carry_in,     // Current carry for carry/borrow forms
    output reg        arith_op,     // Operation touches the flags
    output reg        carry_out,    // New carry
    output reg        half_out,     // New half carry
    output reg        range_out,    // New signed range flag
    output reg        carry_valid   // Carry/half carry are updated
);

    // Nibble and byte sums with an extra bit for the carry out
    reg [4:0]  lo_sum;
    reg [8:0]  full_sum;
    reg [15:0] prod;
    reg        cin;

    // ======================================================================
    // Flag results per operation
    // ======================================================================
    always @* begin
        cin         = (op_code == `OP_SUM) ? 1'b0 : carry_in;
        lo_sum      = 5'h00;
        full_sum    = 9'h000;
        prod        = {8'h00, op_a} * {8'h00, op_b};
        arith_op    = 1'b0;
        carry_out   = 1'b0;
        half_out    = 1'b0;
        range_out   = 1'b0;
        carry_valid = 1'b0;
        case (op_code)
            `OP_SUM, `OP_SUM_CARRY: begin
                lo_sum      = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
                full_sum    = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
                arith_op    = 1'b1;
                carry_valid = 1'b1;
                carry_out   = full_sum[8];
                half_out    = lo_sum[4];
                // Same signs in, other sign out
                range_out   = (op_a[7] == op_b[7]) && (full_sum[7] != op_a[7]);
            end
            `OP_DIFF_BORROW: begin
                lo_sum      = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};
                full_sum    = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
                arith_op    = 1'b1;
                carry_valid = 1'b1;
                carry_out   = full_sum[8];
                half_out    = lo_sum[4];
                range_out   = (op_a[7] != op_b[7]) && (full_sum[7] != op_a[7]);
            end
            `OP_PRODUCT: begin
                arith_op    = 1'b1;
                range_out   = (prod[15:8] != 8'h00);
            end
            `OP_QUOTIENT: begin
                arith_op    = 1'b1;
                range_out   = (op_b == 8'h00);
            end
            default: begin
                arith_op    = 1'b0;
            end
        endcase
    end

endmodule // flag_calc

// ---- power_fsm.v ----
/*
 * Power state machine: run, idle and stop. Idle leaves on an enabled
 * interrupt; stop only on reset, which the synchronous reset handles.
 * Assumes the write strobe marks the completion of the writing instruction.
 */
`timescale 1ns/1ns
`include "core_sfr_map.vh"

module power_fsm (
    input  wire CLK_SYS,        // System clock
    input  wire RST_N,          // Synchronous reset, active low
    input  wire idle_req,       // Write of one to the idle select bit
    input  wire stop_req,       // Write of one to the stop select bit
    input  wire irq_pending,    // An enabled interrupt is asserted
    output reg  cpu_halt_r,     // CPU clock gated
    output reg  osc_stop_r,     // Internal oscillator and digital logic off
    output reg  wake_r          // One-cycle pulse: idle ended by interrupt
);

    // One-hot states
    localparam [2:0] ST_RUN  = 3'b001;
    localparam [2:0] ST_IDLE = 3'b010;
    localparam [2:0] ST_STOP = 3'b100;

    reg [2:0] state_r;          // Current power state
    reg [2:0] state_nxt;        // Next power state

    // ======================================================================
    // Next state
    // ======================================================================
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                // Stop wins when both are written together
                if (stop_req) begin
                    state_nxt = ST_STOP;
                end else if (idle_req) begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (irq_pending) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_STOP: begin
                // Interrupts cannot wake: only reset leaves stop
                state_nxt = ST_STOP;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    // ======================================================================
    // State and outputs; reset ends idle and stop alike
    // ======================================================================
    always @(posedge CLK_SYS) begin
        if (!RST_N) begin
            state_r    <= ST_RUN;
            cpu_halt_r <= 1'b0;
            osc_stop_r <= 1'b0;
            wake_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cpu_halt_r <= (state_nxt != ST_RUN);
            osc_stop_r <= (state_nxt == ST_STOP);
            wake_r     <= (state_r == ST_IDLE) && irq_pending;
        end
    end

endmodule // power_fsm

// ---- tb_core_sfr_bank.sv ----
/* Self-checking bench for the core register bank: register access, flags, stack, power modes.
   Assumes the register map header and the bound checker are compiled alongside. */
`timescale 1ns/1ns
`include "core_sfr_map.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
// Bounded wait; running out counts a mismatch and ends the run
`define WAITF(s) begin for (k = 0; k < 8 && (s) !== 1'b1; k++) tick; \
    if (k == 8) begin failures++; stop_test; end end
module tb_core_sfr_bank;
    reg CLK_SYS = 0, RST_N = 0, SFR_WR = 0, SFR_RD = 0, BIT_WR = 0, BIT_RD = 0, BIT_WDATA = 0;
    reg STACK_STORE = 0, STACK_LOAD = 0, ARITH_WR_B = 0, IRQ_PENDING = 0, IRQ_RETURN = 0;
    reg [7:0] SFR_ADDR = 0, SFR_WDATA = 0, ARITH_RESULT = 0, ARITH_RESULT_B = 0;
    reg [2:0] BIT_POS = 0, ARITH_OP = 0;
    wire [7:0] SFR_RDATA, STACK_ADDR;
    wire [15:0] DATA_POINTER_16_ADDR, FETCH_ADDR;
    wire [4:0] BANK_BASE;
    wire RD_VALID, BIT_RDATA, CPU_HALT, OSC_STOP, IDLE_WAKE, RESUME_NEXT;
    int failures = 0, n_compared = 0, k, i;
    reg [7:0] ra [7] = '{8'h81, 8'h82, 8'h83, 8'h87, 8'hd0, 8'he0, 8'hf0};  // Mapped bytes
    always #5 CLK_SYS = ~CLK_SYS;
    core_sfr_bank u_core_sfr_bank (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SFR_ADDR(SFR_ADDR),
        .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA), .BIT_WR(BIT_WR), .BIT_RD(BIT_RD),
        .BIT_POS(BIT_POS), .BIT_WDATA(BIT_WDATA), .STACK_STORE(STACK_STORE),
        .STACK_LOAD(STACK_LOAD), .ARITH_OP(ARITH_OP), .ARITH_RESULT(ARITH_RESULT),
        .ARITH_WR_B(ARITH_WR_B), .ARITH_RESULT_B(ARITH_RESULT_B), .IRQ_PENDING(IRQ_PENDING),
        .IRQ_RETURN(IRQ_RETURN), .SFR_RDATA(SFR_RDATA), .RD_VALID(RD_VALID),
        .BIT_RDATA(BIT_RDATA), .STACK_ADDR(STACK_ADDR), .DATA_POINTER_16_ADDR(DATA_POINTER_16_ADDR),
        .BANK_BASE(BANK_BASE), .CPU_HALT(CPU_HALT), .OSC_STOP(OSC_STOP), .IDLE_WAKE(IDLE_WAKE),
        .RESUME_NEXT(RESUME_NEXT), .FETCH_ADDR(FETCH_ADDR));
    // ==========================================================================
    // Access tasks: strobes rise 1 ns after an edge and last one cycle
    // ==========================================================================
    task tick; @(posedge CLK_SYS); #1; endtask
    task wr(input [7:0] a, d); tick; SFR_ADDR = a; SFR_WDATA = d; SFR_WR = 1; tick; SFR_WR = 0; endtask
    task rc(input [7:0] a, m, e);
        tick; SFR_ADDR = a; SFR_RD = 1; tick; SFR_RD = 0;
        `CHK("byte read", e, SFR_RDATA & m)
        `CHK("read valid", 1'b1, RD_VALID)
    endtask
    task bw(input [7:0] a, input [2:0] p, input v);
        tick; SFR_ADDR = a; BIT_POS = p; BIT_WDATA = v; BIT_WR = 1; tick; BIT_WR = 0;
    endtask
    task br(input [7:0] a, input [2:0] p, input e);
        tick; SFR_ADDR = a; BIT_POS = p; BIT_RD = 1; tick; BIT_RD = 0;
        `CHK("bit read", e, BIT_RDATA)
        `CHK("bit valid", (a[2:0] == 3'h0), RD_VALID)
    endtask
    // Load operands, clear flags, run one operation, read masked flags
    task ar(input [2:0] op, input [7:0] a, b, m, e);
        wr(`ADDR_PRIMARY_OP, a); wr(`ADDR_SECOND_OP, b); wr(`ADDR_STATUS_FLAGS, 8'h00);
        tick; ARITH_OP = op; ARITH_RESULT = a; tick; ARITH_OP = `OP_NONE;
        rc(`ADDR_STATUS_FLAGS, m, e);
    endtask
    task stop_test;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ==========================================================================
    // Main sequence
    // ==========================================================================
    initial begin
        repeat (2) tick;
        RST_N = 1;
        for (i = 0; i < 7; i++) rc(ra[i], 8'hff, i == 0 ? 8'h07 : 8'h00);
        `CHK("stack addr", 8'h07, STACK_ADDR)
        $display("reset values done");
        wr(8'h82, 8'h34); wr(8'h83, 8'h12); tick;
        `CHK("data_pointer_16", 16'h1234, DATA_POINTER_16_ADDR)
        rc(8'h85, 8'hff, 8'h00);
        bw(8'h82, 2, 0); rc(8'h82, 8'hff, 8'h34);
        br(8'h82, 2, 0);
        $display("data pointer done");
        for (i = 0; i < 4; i++) begin
            wr(8'hd0, i << 3); tick;
            `CHK("bank base", i * 8, BANK_BASE)
        end
        bw(8'hd0, 5, 1); bw(8'hd0, 1, 1); br(8'hd0, 5, 1); br(8'hd0, 1, 1);
        wr(8'he0, 8'h07); rc(8'hd0, 8'h01, 8'h01);
        wr(8'he0, 8'h03); wr(8'hd0, 8'h01); rc(8'hd0, 8'h01, 8'h00);
        $display("status word done");
        ar(`OP_SUM, 8'h0f, 8'h01, 8'hc4, 8'h40);
        ar(`OP_SUM, 8'h80, 8'h80, 8'hc4, 8'h84);
        ar(`OP_SUM_CARRY, 8'h7f, 8'h00, 8'hc4, 8'h00);
        ar(`OP_DIFF_BORROW, 8'h00, 8'h01, 8'hc4, 8'hc0);
        ar(`OP_DIFF_BORROW, 8'h80, 8'h01, 8'hc4, 8'h44);
        ar(`OP_PRODUCT, 8'h10, 8'h10, 8'h04, 8'h04);
        ar(`OP_PRODUCT, 8'h02, 8'h03, 8'h04, 8'h00);
        ar(`OP_QUOTIENT, 8'h06, 8'h00, 8'h04, 8'h04);
        ar(`OP_QUOTIENT, 8'h06, 8'h03, 8'h04, 8'h00);
        $display("arithmetic flags done");
        tick; STACK_STORE = 1; repeat (2) tick; STACK_STORE = 0; tick;
        `CHK("stack addr", 8'h09, STACK_ADDR)
        rc(8'h81, 8'hff, 8'h09);
        $display("stack done");
        wr(8'h82, 8'h55); wr(8'h87, 8'h01); repeat (2) tick;
        `CHK("cpu halt", 1'b1, CPU_HALT)
        wr(8'h82, 8'haa);
        `CHK("data_pointer_16 low", 8'h55, DATA_POINTER_16_ADDR[7:0])
        IRQ_PENDING = 1;
        `WAITF(IDLE_WAKE)
        IRQ_PENDING = 0; tick;
        `CHK("cpu halt", 1'b0, CPU_HALT)
        rc(8'h87, 8'hff, 8'h00);
        tick; IRQ_RETURN = 1; tick; IRQ_RETURN = 0;
        `WAITF(RESUME_NEXT)
        $display("idle done");
        wr(8'h87, 8'h03); repeat (2) tick;
        `CHK("osc stop", 1'b1, OSC_STOP)
        IRQ_PENDING = 1; repeat (5) tick;
        `CHK("osc stop", 1'b1, OSC_STOP)
        IRQ_PENDING = 0; RST_N = 0; repeat (2) tick; RST_N = 1;
        `CHK("osc stop", 1'b0, OSC_STOP)
        `CHK("stack addr", 8'h07, STACK_ADDR)
        `CHK("fetch addr", 16'h0000, FETCH_ADDR)
        rc(8'h82, 8'hff, 8'h00);
        $display("stop done");
        stop_test;
    end
endmodule // tb_core_sfr_bank
